// *** include/stlcp_map.vh ***
`ifndef STLCP_MAP_VH
`define STLCP_MAP_VH

// register offsets within the page (5-bit address)
`define STLCP_ROUTE_AB    5'h00
`define STLCP_ROUTE_CD    5'h01
`define STLCP_ROUTE_EF    5'h02
`define STLCP_ROUTE_GH    5'h03
`define STLCP_ROUTE_IJ    5'h04
`define STLCP_IDLE_CFG    5'h05
`define STLCP_LINE1_SEL   5'h06
`define STLCP_LINE2_SEL   5'h07
`define STLCP_LINE3_SEL   5'h08
`define STLCP_LINE4_SEL   5'h09
`define STLCP_LINE5_SEL   5'h0A
`define STLCP_RED_ON_HI   5'h0B
`define STLCP_RED_ON_LO   5'h0C
`define STLCP_RED_OFF_HI  5'h0D
`define STLCP_RED_OFF_LO  5'h0E
`define STLCP_GRN_ON_HI   5'h0F
`define STLCP_GRN_ON_LO   5'h10
`define STLCP_GRN_OFF_HI  5'h11
`define STLCP_GRN_OFF_LO  5'h12
`define STLCP_BLU_ON_HI   5'h13
`define STLCP_BLU_ON_LO   5'h14
`define STLCP_BLU_OFF_HI  5'h15
`define STLCP_BLU_OFF_LO  5'h16
`define STLCP_IR1_ON_HI   5'h17
`define STLCP_IR1_ON_LO   5'h18
`define STLCP_IR1_OFF_HI  5'h19
`define STLCP_IR1_OFF_LO  5'h1A
`define STLCP_IR2_ON_HI   5'h1B
`define STLCP_IR2_ON_LO   5'h1C
`define STLCP_PAGE_SEL    5'h1F

// bank size and layout of each lamp's group of four registers
`define STLCP_NUM_REGS    29
`define STLCP_LAMP_STRIDE 4
`define STLCP_SLOT_ON_HI  2'h0
`define STLCP_SLOT_ON_LO  2'h1
`define STLCP_SLOT_OFF_HI 2'h2
`define STLCP_SLOT_OFF_LO 2'h3

// page number of this page
`define STLCP_THIS_PAGE   3'h3

// field masks: writable bits per register kind
`define STLCP_MASK_FULL   8'hFF
`define STLCP_MASK_IDLE   8'hF9
`define STLCP_MASK_LINE   8'h1F
`define STLCP_MASK_ON_HI  8'h1F
`define STLCP_MASK_OFF_HI 8'h0F
`define STLCP_MASK_PAGE   8'h07

// field positions
`define STLCP_SHM_BIT     4
`define STLCP_OVL_BIT     0

// reset values of the lamp position block, offsets 0x0B..0x1C
`define STLCP_RST_ON_HI   8'h00
`define STLCP_RST_RED_ON  8'h11
`define STLCP_RST_GRN_ON  8'h12
`define STLCP_RST_BLU_ON  8'h13
`define STLCP_RST_IR1_ON  8'h14
`define STLCP_RST_IR2_ON  8'h15
`define STLCP_RST_OFF_HI  8'h03
`define STLCP_RST_RED_OFF 8'h06
`define STLCP_RST_GRN_OFF 8'h00
`define STLCP_RST_BLU_OFF 8'h30
`define STLCP_RST_IR1_OFF 8'h30
`define STLCP_RST_OTHER   8'h00
`define STLCP_RST_PAGE    3'h0

`endif

// *** verilog/stlcp_lamp_page.v ***
// Function
// - page-select at 1F; value 3 opens page
// - page-select reachable on every page
// - five line lamp-enable registers, bits 4..0
// - lamp positions 12 bit, high nibble+low byte
// - on-high bit 4 merges sample-hold pulse
// - on-low resets 0x11..0x15, on-high zero
// - off positions reset 0x306,0x300,0x330,0x330
// - only three page bits kept, rest zero
`timescale 1ns/1ns
`include "stlcp_map.vh"

module stlcp_lamp_page (
    clk,
    srst,
    addr,
    wdata,
    wr_stb,
    rd_stb,
    rdata,
    page_sel,
    page_active,
    route_pins,
    idle_levels,
    pulse_light_overlap_allow,
    line_light_en,
    light_on_pos,
    light_off_pos,
    sample_hold_merge
);
    input  wire        clk;
    input  wire        srst;
    input  wire [4:0]  addr;
    input  wire [7:0]  wdata;
    input  wire        wr_stb;
    input  wire        rd_stb;
    output reg  [7:0]  rdata;
    output wire [2:0]  page_sel;
    output wire        page_active;
    output wire [39:0] route_pins;
    output wire [4:0]  idle_levels;
    output wire        pulse_light_overlap_allow;
    output wire [24:0] line_light_en;
    output wire [59:0] light_on_pos;
    output wire [59:0] light_off_pos;
    output wire [4:0]  sample_hold_merge;

    ////////////////////////////////////////////////////////////////////////
    // storage: 29 page registers (0x00..0x1C) and the page selector
    reg  [7:0] regs_q [0:28];
    reg  [2:0] page_q;
    reg  [7:0] rdata_d;
    wire       hit_page;
    wire       hit_bank;
    wire       wr_bank;
    wire       rd_bank;
    integer    k;

    ////////////////////////////////////////////////////////////////////////
    // offset decoding, shared by the mask and the read and write paths

    // offset lies inside the paged bank; 0x1D and 0x1E hold nothing here
    function in_bank;
        input [4:0] a;
        begin
            in_bank = (a <= `STLCP_IR2_ON_LO);
        end
    endfunction

    // offset is one of the five pin-routing registers
    function is_route;
        input [4:0] a;
        begin
            is_route = (a <= `STLCP_ROUTE_IJ);
        end
    endfunction

    // offset is the idle-level and overlap register
    function is_idle;
        input [4:0] a;
        begin
            is_idle = (a == `STLCP_IDLE_CFG);
        end
    endfunction

    // offset is one of the five line lamp-enable registers
    function is_line;
        input [4:0] a;
        begin
            is_line = (a >= `STLCP_LINE1_SEL) && (a <= `STLCP_LINE5_SEL);
        end
    endfunction

    // slot inside a lamp's group of four registers:
    // on high, on low, off high, off low
    function [1:0] lamp_slot;
        input [4:0] a;
        reg   [4:0] rel;
        begin
            rel       = a - `STLCP_RED_ON_HI;
            lamp_slot = rel[1:0];
        end
    endfunction

    // offset belongs to the lamp position block
    function in_lamps;
        input [4:0] a;
        begin
            in_lamps = (a >= `STLCP_RED_ON_HI) && in_bank(a);
        end
    endfunction

    // turn-on high register: position nibble plus the merge flag
    function is_on_hi;
        input [4:0] a;
        begin
            is_on_hi = in_lamps(a) && (lamp_slot(a) == `STLCP_SLOT_ON_HI);
        end
    endfunction

    // turn-off high register: position nibble only
    function is_off_hi;
        input [4:0] a;
        begin
            is_off_hi = in_lamps(a) && (lamp_slot(a) == `STLCP_SLOT_OFF_HI);
        end
    endfunction

    // low byte of either position, all eight bits used
    function is_pos_lo;
        input [4:0] a;
        begin
            is_pos_lo = in_lamps(a) && ((lamp_slot(a) == `STLCP_SLOT_ON_LO) ||
                                        (lamp_slot(a) == `STLCP_SLOT_OFF_LO));
        end
    endfunction

    // writable-bit mask per offset; reserved bits stay zero so a
    // whole-byte write never disturbs a neighbouring field
    function [7:0] stlcp_mask;
        input [4:0] a;
        begin
            stlcp_mask = 8'h00;
            if (is_route(a))
                stlcp_mask = `STLCP_MASK_FULL;
            else if (is_idle(a))
                stlcp_mask = `STLCP_MASK_IDLE;
            else if (is_line(a))
                stlcp_mask = `STLCP_MASK_LINE;
            else if (is_on_hi(a))
                stlcp_mask = `STLCP_MASK_ON_HI;
            else if (is_off_hi(a))
                stlcp_mask = `STLCP_MASK_OFF_HI;
            else if (is_pos_lo(a))
                stlcp_mask = `STLCP_MASK_FULL;
        end
    endfunction

    // reset value per offset
    function [7:0] stlcp_rst;
        input [4:0] a;
        begin
            case (a)
                // turn-on high registers clear, merge flags off
                `STLCP_RED_ON_HI:  stlcp_rst = `STLCP_RST_ON_HI;
                `STLCP_GRN_ON_HI:  stlcp_rst = `STLCP_RST_ON_HI;
                `STLCP_BLU_ON_HI:  stlcp_rst = `STLCP_RST_ON_HI;
                `STLCP_IR1_ON_HI:  stlcp_rst = `STLCP_RST_ON_HI;
                `STLCP_IR2_ON_HI:  stlcp_rst = `STLCP_RST_ON_HI;

                // turn-on low bytes, one step apart per lamp
                `STLCP_RED_ON_LO:  stlcp_rst = `STLCP_RST_RED_ON;
                `STLCP_GRN_ON_LO:  stlcp_rst = `STLCP_RST_GRN_ON;
                `STLCP_BLU_ON_LO:  stlcp_rst = `STLCP_RST_BLU_ON;
                `STLCP_IR1_ON_LO:  stlcp_rst = `STLCP_RST_IR1_ON;
                `STLCP_IR2_ON_LO:  stlcp_rst = `STLCP_RST_IR2_ON;

                // turn-off high nibbles
                `STLCP_RED_OFF_HI: stlcp_rst = `STLCP_RST_OFF_HI;
                `STLCP_GRN_OFF_HI: stlcp_rst = `STLCP_RST_OFF_HI;
                `STLCP_BLU_OFF_HI: stlcp_rst = `STLCP_RST_OFF_HI;
                `STLCP_IR1_OFF_HI: stlcp_rst = `STLCP_RST_OFF_HI;

                // turn-off low bytes
                `STLCP_RED_OFF_LO: stlcp_rst = `STLCP_RST_RED_OFF;
                `STLCP_GRN_OFF_LO: stlcp_rst = `STLCP_RST_GRN_OFF;
                `STLCP_BLU_OFF_LO: stlcp_rst = `STLCP_RST_BLU_OFF;
                `STLCP_IR1_OFF_LO: stlcp_rst = `STLCP_RST_IR1_OFF;

                // routing, idle, line and unused offsets clear
                default:           stlcp_rst = `STLCP_RST_OTHER;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // page selector lives outside paging so it is always reachable
    assign hit_page    = (addr == `STLCP_PAGE_SEL);
    assign page_active = (page_q == `STLCP_THIS_PAGE);
    assign page_sel    = page_q;

    // bank accesses count only while this page is the active one
    assign hit_bank = in_bank(addr);
    assign wr_bank  = wr_stb && page_active && hit_bank;
    assign rd_bank  = rd_stb && page_active && hit_bank;

    // selector keeps only the three page bits
    always @(posedge clk) begin
        if (srst) begin
            page_q <= `STLCP_RST_PAGE;
        end else if (wr_stb && hit_page) begin
            page_q <= wdata[2:0];
        end
    end

    // paged registers in one process, so every word has a single driver;
    // reserved bits are dropped on the way in
    always @(posedge clk) begin
        if (srst) begin
            for (k = 0; k < `STLCP_NUM_REGS; k = k + 1) begin
                regs_q[k] <= stlcp_rst(k[4:0]);
            end
        end else if (wr_bank) begin
            regs_q[addr] <= wdata & stlcp_mask(addr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux: selector, one bank word, or zero for anything else
    always @* begin
        rdata_d = 8'h00;
        if (rd_stb && hit_page) begin
            rdata_d = {5'h00, page_q};
        end else if (rd_bank) begin
            case (addr)
                `STLCP_ROUTE_AB:   rdata_d = regs_q[`STLCP_ROUTE_AB]   & `STLCP_MASK_FULL;
                `STLCP_ROUTE_CD:   rdata_d = regs_q[`STLCP_ROUTE_CD]   & `STLCP_MASK_FULL;
                `STLCP_ROUTE_EF:   rdata_d = regs_q[`STLCP_ROUTE_EF]   & `STLCP_MASK_FULL;
                `STLCP_ROUTE_GH:   rdata_d = regs_q[`STLCP_ROUTE_GH]   & `STLCP_MASK_FULL;
                `STLCP_ROUTE_IJ:   rdata_d = regs_q[`STLCP_ROUTE_IJ]   & `STLCP_MASK_FULL;
                `STLCP_IDLE_CFG:   rdata_d = regs_q[`STLCP_IDLE_CFG]   & `STLCP_MASK_IDLE;
                `STLCP_LINE1_SEL:  rdata_d = regs_q[`STLCP_LINE1_SEL]  & `STLCP_MASK_LINE;
                `STLCP_LINE2_SEL:  rdata_d = regs_q[`STLCP_LINE2_SEL]  & `STLCP_MASK_LINE;
                `STLCP_LINE3_SEL:  rdata_d = regs_q[`STLCP_LINE3_SEL]  & `STLCP_MASK_LINE;
                `STLCP_LINE4_SEL:  rdata_d = regs_q[`STLCP_LINE4_SEL]  & `STLCP_MASK_LINE;
                `STLCP_LINE5_SEL:  rdata_d = regs_q[`STLCP_LINE5_SEL]  & `STLCP_MASK_LINE;
                `STLCP_RED_ON_HI:  rdata_d = regs_q[`STLCP_RED_ON_HI]  & `STLCP_MASK_ON_HI;
                `STLCP_RED_ON_LO:  rdata_d = regs_q[`STLCP_RED_ON_LO]  & `STLCP_MASK_FULL;
                `STLCP_RED_OFF_HI: rdata_d = regs_q[`STLCP_RED_OFF_HI] & `STLCP_MASK_OFF_HI;
                `STLCP_RED_OFF_LO: rdata_d = regs_q[`STLCP_RED_OFF_LO] & `STLCP_MASK_FULL;
                `STLCP_GRN_ON_HI:  rdata_d = regs_q[`STLCP_GRN_ON_HI]  & `STLCP_MASK_ON_HI;
                `STLCP_GRN_ON_LO:  rdata_d = regs_q[`STLCP_GRN_ON_LO]  & `STLCP_MASK_FULL;
                `STLCP_GRN_OFF_HI: rdata_d = regs_q[`STLCP_GRN_OFF_HI] & `STLCP_MASK_OFF_HI;
                `STLCP_GRN_OFF_LO: rdata_d = regs_q[`STLCP_GRN_OFF_LO] & `STLCP_MASK_FULL;
                `STLCP_BLU_ON_HI:  rdata_d = regs_q[`STLCP_BLU_ON_HI]  & `STLCP_MASK_ON_HI;
                `STLCP_BLU_ON_LO:  rdata_d = regs_q[`STLCP_BLU_ON_LO]  & `STLCP_MASK_FULL;
                `STLCP_BLU_OFF_HI: rdata_d = regs_q[`STLCP_BLU_OFF_HI] & `STLCP_MASK_OFF_HI;
                `STLCP_BLU_OFF_LO: rdata_d = regs_q[`STLCP_BLU_OFF_LO] & `STLCP_MASK_FULL;
                `STLCP_IR1_ON_HI:  rdata_d = regs_q[`STLCP_IR1_ON_HI]  & `STLCP_MASK_ON_HI;
                `STLCP_IR1_ON_LO:  rdata_d = regs_q[`STLCP_IR1_ON_LO]  & `STLCP_MASK_FULL;
                `STLCP_IR1_OFF_HI: rdata_d = regs_q[`STLCP_IR1_OFF_HI] & `STLCP_MASK_OFF_HI;
                `STLCP_IR1_OFF_LO: rdata_d = regs_q[`STLCP_IR1_OFF_LO] & `STLCP_MASK_FULL;
                `STLCP_IR2_ON_HI:  rdata_d = regs_q[`STLCP_IR2_ON_HI]  & `STLCP_MASK_ON_HI;
                `STLCP_IR2_ON_LO:  rdata_d = regs_q[`STLCP_IR2_ON_LO]  & `STLCP_MASK_FULL;
                default:           rdata_d = 8'h00;
            endcase
        end
    end

    // read data valid only in the cycle after the strobe, zero otherwise
    always @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded configuration toward the timing generator
    // idle levels: bit 4 red down to bit 0 second infrared
    assign idle_levels               = regs_q[`STLCP_IDLE_CFG][7:3];
    assign pulse_light_overlap_allow = regs_q[`STLCP_IDLE_CFG][`STLCP_OVL_BIT];

    genvar gp;
    generate
        // pin routing: upper nibble first pin, lower nibble next
        for (gp = 0; gp < 5; gp = gp + 1) begin : g_route
            assign route_pins[8*gp+7:8*gp] = regs_q[`STLCP_ROUTE_AB + gp];
        end
        // line slot lamp enables, bit 4 red .. bit 0 second infrared
        for (gp = 0; gp < 5; gp = gp + 1) begin : g_line
            assign line_light_en[5*gp+4:5*gp] = regs_q[`STLCP_LINE1_SEL + gp][4:0];
        end
        // turn-on positions and merge flags, four registers per lamp
        for (gp = 0; gp < 5; gp = gp + 1) begin : g_lamp
            wire [4:0] on_hi;
            wire [7:0] on_lo;
            assign on_hi = regs_q[`STLCP_RED_ON_HI + `STLCP_LAMP_STRIDE*gp][4:0];
            assign on_lo = regs_q[`STLCP_RED_ON_HI + `STLCP_LAMP_STRIDE*gp + 1];
            assign light_on_pos[12*gp+11:12*gp] = {on_hi[3:0], on_lo};
            assign sample_hold_merge[gp]        = on_hi[`STLCP_SHM_BIT];
        end
        // turn-off positions of the four lamps held on this page
        for (gp = 0; gp < 4; gp = gp + 1) begin : g_off
            wire [3:0] off_hi;
            wire [7:0] off_lo;
            assign off_hi = regs_q[`STLCP_RED_ON_HI + `STLCP_LAMP_STRIDE*gp + 2][3:0];
            assign off_lo = regs_q[`STLCP_RED_ON_HI + `STLCP_LAMP_STRIDE*gp + 3];
            assign light_off_pos[12*gp+11:12*gp] = {off_hi, off_lo};
        end
    endgenerate

    // second infrared off position sits on another page
    assign light_off_pos[59:48] = 12'h000;

endmodule

// *** sim/stlcp_properties.sv ***
`timescale 1ns/1ns
module stlcp_properties (
    input wire        clk,
    input wire        srst,
    input wire [4:0]  addr,
    input wire [7:0]  wdata,
    input wire        wr_stb,
    input wire        rd_stb,
    input wire [7:0]  rdata,
    input wire [2:0]  page_sel,
    input wire        page_active,
    input wire [24:0] line_light_en,
    input wire [59:0] light_on_pos,
    input wire [59:0] light_off_pos,
    input wire [4:0]  sample_hold_merge
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////
    // page select and read path
    chk_page_write: assert property (wr_stb && addr == 5'h1F |=> page_sel == $past(wdata[2:0]))
        else $error("page select not stored");
    chk_page_decode: assert property (page_active == (page_sel == 3'h3))
        else $error("page decode wrong");
    chk_page_read: assert property (rd_stb && addr == 5'h1F |=> rdata == {5'h00, $past(page_sel)})
        else $error("page select readback wrong");
    chk_read_quiet: assert property (!rd_stb |=> rdata == 8'h00)
        else $error("read data outside its cycle");
    chk_off_page: assert property (rd_stb && addr < 5'h1D && !page_active |=> rdata == 8'h00)
        else $error("other page read not zero");
    ////////////////////////////////////////////////////////////
    // field updates and reset state
    chk_line_write: assert property (wr_stb && page_active && addr == 5'h06 |=> line_light_en[4:0] == $past(wdata[4:0]))
        else $error("line select not stored");
    chk_on_high: assert property (wr_stb && page_active && addr == 5'h0B |=>
        sample_hold_merge[0] == $past(wdata[4]) && light_on_pos[11:8] == $past(wdata[3:0]))
        else $error("on high fields wrong");
    chk_reset_pos: assert property ($fell(srst) |-> light_on_pos == 60'h015014013012011 &&
        light_off_pos == 60'h000330330300306)
        else $error("position reset values wrong");
    cover property (rd_stb && page_active);
    cover property (wr_stb && addr == 5'h1F);
    cover property (wr_stb && !page_active && addr == 5'h06);
endmodule

// *** sim/sensor_timing_lamp_config_page_tb.sv ***
`timescale 1ns/1ns
module sensor_timing_lamp_config_page_tb;
    reg         clk = 0, srst = 1, wr_stb = 0, rd_stb = 0;
    reg  [4:0]  addr = 0;
    reg  [7:0]  wdata = 0;
    wire [7:0]  rdata;
    wire [2:0]  page_sel;
    wire        page_active, pulse_light_overlap_allow;
    wire [39:0] route_pins;
    wire [4:0]  idle_levels, sample_hold_merge;
    wire [24:0] line_light_en;
    wire [59:0] light_on_pos, light_off_pos;
    integer     miscompares = 0, n_checks = 0, cyc = 0, i;
    stlcp_lamp_page i_dut (
        .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .page_sel(page_sel), .page_active(page_active), .route_pins(route_pins),
        .idle_levels(idle_levels), .pulse_light_overlap_allow(pulse_light_overlap_allow),
        .line_light_en(line_light_en), .light_on_pos(light_on_pos), .light_off_pos(light_off_pos),
        .sample_hold_merge(sample_hold_merge));
    initial forever #25 clk = ~clk;
    ////////////////////////////////////////////////////////////
    // compare, bus tasks, closing report
    task cmp(input [71:0] got, input [71:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [4:0] a, input [7:0] d);
        begin
            @(posedge clk) {wr_stb, addr, wdata} <= {1'b1, a, d};
            @(posedge clk) wr_stb <= 1'b0;
        end
    endtask
    task rd(input [4:0] a, input [7:0] x);
        begin
            @(posedge clk) {rd_stb, addr} <= {1'b1, a};
            @(posedge clk) rd_stb <= 1'b0;
            @(negedge clk) cmp(rdata, x);
        end
    endtask
    task tally_and_finish;
        begin
            if (miscompares == 0 && n_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // reset value and writable mask per offset
    function [7:0] rst_val(input [4:0] a);
        case (a)
            5'h0C: rst_val = 8'h11;
            5'h10: rst_val = 8'h12;
            5'h14: rst_val = 8'h13;
            5'h18: rst_val = 8'h14;
            5'h1C: rst_val = 8'h15;
            5'h0D, 5'h11, 5'h15, 5'h19: rst_val = 8'h03;
            5'h0E: rst_val = 8'h06;
            5'h16, 5'h1A: rst_val = 8'h30;
            default: rst_val = 8'h00;
        endcase
    endfunction
    function [7:0] mask(input [4:0] a);
        case (a)
            5'h05: mask = 8'hF9;
            5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0F, 5'h13, 5'h17, 5'h1B: mask = 8'h1F;
            5'h0D, 5'h11, 5'h15, 5'h19: mask = 8'h0F;
            5'h1D, 5'h1E: mask = 8'h00;
            default: mask = 8'hFF;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd(5'h1F, 8'h00);
        wr(5'h06, 8'h1F);
        rd(5'h0C, 8'h00);
        wr(5'h1F, 8'hFB);
        rd(5'h1F, 8'h03);
        for (i = 0; i < 31; i = i + 1) rd(i[4:0], rst_val(i[4:0]));
        for (i = 0; i < 31; i = i + 1) wr(i[4:0], 8'hFF);
        for (i = 0; i < 31; i = i + 1) rd(i[4:0], mask(i[4:0]));
        cmp({route_pins, line_light_en, sample_hold_merge}, {40'hFFFFFFFFFF, 25'h1FFFFFF, 5'h1F});
        cmp({light_on_pos[11:0], light_off_pos}, {12'hFFF, 60'h000FFFFFFFFFFFF});
        cmp({idle_levels, pulse_light_overlap_allow, page_active, page_sel}, {5'h1F, 1'b1, 1'b1, 3'h3});
        // mid-run reset brings every field back to its reset value
        @(posedge clk) srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk) cmp({page_sel, idle_levels, pulse_light_overlap_allow, light_on_pos}, {9'h000, 60'h015014013012011});
        cmp({route_pins, line_light_en, sample_hold_merge}, 70'h0);
        cmp(light_off_pos, 60'h000330330300306);
        wr(5'h1F, 8'h01);
        rd(5'h0C, 8'h00);
        rd(5'h1F, 8'h01);
        tally_and_finish;
    end
    // hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            miscompares = miscompares + 1;
            tally_and_finish;
        end
    end
endmodule
bind stlcp_lamp_page stlcp_properties i_chk (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .page_sel(page_sel), .page_active(page_active), .line_light_en(line_light_en),
    .light_on_pos(light_on_pos), .light_off_pos(light_off_pos), .sample_hold_merge(sample_hold_merge));
